/* rtl/mcuie_core.sv */
// Operation
// RULE1 - memory load takes one cycle, sets zero only; store takes one, no flags
// RULE2 - bank-0 immediate store reaches only 80h..87h, one cycle, no flags
// RULE3 - exchange swaps accumulator and memory, no flags, one cycle plus N
// RULE4 - table read fetches ROM at Y:Z into R and A, two cycles
// RULE5 - add with carry sets carry on carry-out, updates C, DC, Z
// RULE6 - sum without carry-in, carry on carry-out, updates C, DC, Z
// RULE7 - subtract with borrow uses inverted carry; carry clear means borrow
// RULE8 - difference without borrow-in; carry clear on borrow; C, DC, Z
// RULE9 - decimal adjust of accumulator in one cycle, carry only
// RULE10 - product over two cycles, low to A, high to R, zero from A
// RULE11 - AND, OR, XOR update zero only; memory form costs one plus N
// RULE12 - nibble swap of memory byte to A or memory, no flags
// RULE13 - rotates through carry touch carry only, to A or memory
// RULE14 - clear byte one cycle; bit set or clear one plus N; no flags
// RULE15 - compare subtracts without storing, sets C and Z, skips when equal
// RULE16 - increment skips when result is zero, no flags
// RULE17 - decrement skips when result is zero, no flags
// RULE18 - bit tests skip on selected bit value, no flags
// RULE19 - jump loads page bits into PC 15:14, operand into 13:0, two cycles
// RULE20 - call pushes the program counter then jumps, two cycles
// RULE21 - returns pop PC in two cycles; interrupt return sets global enable
// RULE22 - a taken skip adds exactly one cycle
// RULE23 - write penalty is zero for bank-0 80h..FFh, else one
// RULE24 - half carry is carry out of bit 3, or its borrow
// RULE25 - no-operation just advances the program counter in one cycle
`default_nettype none
module mcuie_core
  import mcuie_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF,
  parameter int BANK_W = BANK_W_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [PC_W-1:0] romAddr,
  input wire logic [15:0] romData,
  output logic [BANK_W+7:0] ramRdAddr,
  input wire logic [7:0] ramRdData,
  output logic ramWe,
  output logic [BANK_W+7:0] ramWrAddr,
  output logic [7:0] ramWrData,
  input wire logic [1:0] romPageBits,
  input wire logic gieClear,
  output logic gie,
  output logic [7:0] acc,
  output logic carryFlag,
  output logic halfCarryFlag,
  output logic zeroResultFlag
);
  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  if ((STACK_DEPTH < 2) || ((STACK_DEPTH & (STACK_DEPTH - 1)) != 0) || (BANK_W < 1) || (BANK_W > 8)) begin : g_chk
    $error("stack depth must be a power of two, bank width 1..8");
  end

  mcuie_alu_if aluBus ();
  mcuie_alu u_alu (.bus(aluBus));

  mcuie_state_e state;
  logic skipNext, movcPend;
  logic [PC_W-1:0] pc;
  logic [7:0] rHold, ptrY, ptrZ;
  logic [BANK_W-1:0] rbank;
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;

  ////////////////////////////////////////////////////////////////////////////
  // instruction fields
  logic [1:0] cls;
  logic [5:0] op;
  logic [7:0] opnd, addr, memVal, wrData, bitVal;
  logic [2:0] bop, bitIdx;
  logic [BANK_W-1:0] bank;
  logic exec, isMisc, isBit, isB0Imm, b0, intHit, inBank0Sys;
  logic [15:0] prod;
  logic [PC_W-1:0] jumpTarget, retAddr;

  assign cls = romData[15:14];
  assign op = romData[13:8];
  assign opnd = romData[7:0];
  assign bop = romData[13:11];
  assign bitIdx = romData[10:8];
  // a squashed slot still takes its cycle but does nothing else
  assign exec = (state == ST_RUN) && !skipNext;
  assign isMisc = (cls == CLS_MISC);
  assign isBit = (cls == CLS_BIT);
  assign isB0Imm = isMisc && (op[5:3] == B0IMM_GRP);
  assign b0 = isB0Imm || (isBit && bop[1]) || (isMisc && (op inside {OP_BANK0_TRANSFER_AM, OP_BANK0_TRANSFER_MA, OP_BANK0_EXCHANGE, OP_BANK0_SUM_MA}));
  // RULE2 immediate store window
  assign addr = isB0Imm ? (B0IMM_BASE | {5'h00, op[2:0]}) : opnd;
  assign bank = b0 ? '0 : rbank;
  assign inBank0Sys = (bank == '0) && addr[7];
  assign intHit = (bank == '0) && (addr inside {SYS_R, SYS_Y, SYS_Z, SYS_PFLAG, SYS_RBANK});
  assign ramRdAddr = {bank, addr};
  assign romAddr = movcPend ? {ptrY, ptrZ} : pc;
  assign prod = {8'h00, acc} * {8'h00, memVal};
  assign jumpTarget = {romPageBits, romData[13:0]};
  assign retAddr = stack[sp - 1'b1];

  // operand fetch; a write still in flight is forwarded so back-to-back access sees it
  always_comb begin
    memVal = ramRdData;
    if (ramWe && (ramWrAddr == ramRdAddr)) memVal = ramWrData;
    if (bank == '0) begin
      case (addr)
        SYS_R: memVal = rHold;
        SYS_Y: memVal = ptrY;
        SYS_Z: memVal = ptrZ;
        SYS_PFLAG: memVal = {5'h00, carryFlag, halfCarryFlag, zeroResultFlag};
        SYS_RBANK: memVal = 8'(rbank);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  mcuie_alu_e aluOp;
  logic memDest, penalty, bImm, aMem, bZero, storeAcc, wrA, updC, updDC, updZ, cin;
  logic skipChk, skipTake, isMul, isMovc, isRet, isReti, needN, stall, doWr;

  always_comb begin
    aluOp = ALU_PASS;
    memDest = 1'b0;
    penalty = 1'b1;
    aMem = 1'b0;
    bZero = 1'b0;
    storeAcc = 1'b0;
    wrA = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    updZ = 1'b0;
    cin = 1'b0;
    skipChk = 1'b0;
    isMul = 1'b0;
    isMovc = 1'b0;
    isRet = 1'b0;
    isReti = 1'b0;
    bImm = isMisc && (op inside {OP_MOV_AI, OP_ADD_AI, OP_SUB_AI, OP_AND_AI, OP_OR_AI, OP_XOR_AI, OP_COMPARE_SKIP_AI});
    if (isBit) begin
      // RULE14 bit write-back
      memDest = !bop[2];
      // RULE18 bit test skip
      skipChk = bop[2];
    end else if (isB0Imm) begin
      memDest = 1'b1;
      penalty = 1'b0;
    end else if (isMisc) begin
      unique case (op)
        // RULE25 nothing happens
        OP_NOP: ;
        // RULE1 load sets zero
        OP_MOV_AM, OP_BANK0_TRANSFER_AM: begin
          wrA = 1'b1;
          updZ = 1'b1;
        end
        // RULE1 store no penalty
        OP_MOV_MA, OP_BANK0_TRANSFER_MA: begin
          memDest = 1'b1;
          storeAcc = 1'b1;
          penalty = 1'b0;
        end
        OP_MOV_AI: wrA = 1'b1;
        // RULE3 swap both ways
        OP_XCH, OP_BANK0_EXCHANGE: begin
          wrA = 1'b1;
          memDest = 1'b1;
          storeAcc = 1'b1;
        end
        // RULE4 table read start
        OP_ROM_TABLE_READ: isMovc = 1'b1;
        // RULE5 add with carry
        OP_ADC_AM, OP_ADC_MA: begin
          aluOp = ALU_ADD;
          cin = carryFlag;
          {updC, updDC, updZ} = 3'h7;
        end
        // RULE6 plain sum
        OP_ADD_AM, OP_ADD_MA, OP_BANK0_SUM_MA, OP_ADD_AI: begin
          aluOp = ALU_ADD;
          {updC, updDC, updZ} = 3'h7;
        end
        // RULE7 borrow from carry
        OP_SBC_AM, OP_SBC_MA: begin
          aluOp = ALU_SUB;
          cin = carryFlag;
          {updC, updDC, updZ} = 3'h7;
        end
        // RULE8 plain difference
        OP_SUB_AM, OP_SUB_MA, OP_SUB_AI: begin
          aluOp = ALU_SUB;
          cin = 1'b1;
          {updC, updDC, updZ} = 3'h7;
        end
        // RULE9 decimal adjust
        OP_DAA: begin
          aluOp = ALU_DAA;
          cin = carryFlag;
          updC = 1'b1;
        end
        // RULE10 product zero flag
        OP_MUL: begin
          isMul = 1'b1;
          updZ = 1'b1;
        end
        // RULE11 logic zero only
        OP_AND_AM, OP_AND_MA, OP_AND_AI: begin
          aluOp = ALU_AND;
          updZ = 1'b1;
        end
        OP_OR_AM, OP_OR_MA, OP_OR_AI: begin
          aluOp = ALU_OR;
          updZ = 1'b1;
        end
        OP_XOR_AM, OP_XOR_MA, OP_XOR_AI: begin
          aluOp = ALU_XOR;
          updZ = 1'b1;
        end
        // RULE12 nibble swap
        OP_SWAP, OP_NIBBLE_EXCHANGE_MEM: begin
          aluOp = ALU_SWAP;
          aMem = 1'b1;
        end
        // RULE13 rotate via carry
        OP_RRC, OP_ROTATE_RIGHT_CARRY_MEM, OP_RLC, OP_ROTATE_LEFT_CARRY_MEM: begin
          aluOp = (op == OP_RRC || op == OP_ROTATE_RIGHT_CARRY_MEM) ? ALU_RRC : ALU_RLC;
          aMem = 1'b1;
          cin = carryFlag;
          updC = 1'b1;
        end
        // RULE14 clear in one cycle
        OP_CLR: begin
          memDest = 1'b1;
          bZero = 1'b1;
          penalty = 1'b0;
        end
        // RULE15 compare and skip
        OP_COMPARE_SKIP_AI, OP_COMPARE_SKIP_AM: begin
          aluOp = ALU_SUB;
          cin = 1'b1;
          updC = 1'b1;
          updZ = 1'b1;
          skipChk = 1'b1;
        end
        // RULE16 increment skip
        OP_INCREMENT_SKIP_ACC, OP_INCREMENT_MEM_SKIP: begin
          aluOp = ALU_INC;
          aMem = 1'b1;
          skipChk = 1'b1;
        end
        // RULE17 decrement skip
        OP_DECREMENT_SKIP_ACC, OP_DECREMENT_MEM_SKIP: begin
          aluOp = ALU_DEC;
          aMem = 1'b1;
          skipChk = 1'b1;
        end
        OP_RET: isRet = 1'b1;
        OP_INTERRUPT_RETURN: isReti = 1'b1;
        default: ;
      endcase
      if (op inside {OP_ADC_MA, OP_ADD_MA, OP_BANK0_SUM_MA, OP_SBC_MA, OP_SUB_MA, OP_AND_MA, OP_OR_MA, OP_XOR_MA,
                     OP_NIBBLE_EXCHANGE_MEM, OP_ROTATE_RIGHT_CARRY_MEM, OP_ROTATE_LEFT_CARRY_MEM, OP_INCREMENT_MEM_SKIP, OP_DECREMENT_MEM_SKIP}) begin
        memDest = 1'b1;
      end else if ((aluOp != ALU_PASS) && (op != OP_COMPARE_SKIP_AI) && (op != OP_COMPARE_SKIP_AM)) begin
        wrA = 1'b1;
      end
    end
  end

  assign aluBus.op = aluOp;
  assign aluBus.a = aMem ? memVal : acc;
  assign aluBus.b = bZero ? 8'h00 : (bImm ? opnd : memVal);
  assign aluBus.cin = cin;
  assign aluBus.hcIn = halfCarryFlag;

  // bit-modified copy of the operand
  always_comb begin
    bitVal = memVal;
    bitVal[bitIdx] = bop[0];
  end
  assign wrData = storeAcc ? acc : (isBit ? bitVal : (isB0Imm ? opnd : aluBus.res));
  assign skipTake = skipChk && (isBit ? (memVal[bitIdx] == bop[0]) : (aluBus.res == 8'h00));
  // RULE23 penalty only off the system page
  assign needN = memDest && penalty && !inBank0Sys;
  assign stall = needN || isMovc || isMul || isRet || isReti || (cls == CLS_JMP) || (cls == CLS_CALL);
  assign doWr = exec && memDest;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: one wait state covers both the two-cycle ops and N
  // RULE22 skip squashes one slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
      skipNext <= 1'b0;
      movcPend <= 1'b0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (exec) begin
            skipNext <= skipTake;
            movcPend <= isMovc;
            if (stall) state <= ST_WAIT;
          end else begin
            skipNext <= 1'b0;
          end
        end
        ST_WAIT: begin
          state <= ST_RUN;
          movcPend <= 1'b0;
        end
      endcase
    end
  end

  // program counter and stack pointer; the stack wraps silently when overrun
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= PC_RST;
      sp <= '0;
    end else if (state == ST_RUN) begin
      pc <= pc + 16'h0001;
      if (exec) begin
        // RULE19 page and operand
        if ((cls == CLS_JMP) || (cls == CLS_CALL)) pc <= jumpTarget;
        // RULE20 push before jump
        if (cls == CLS_CALL) sp <= sp + 1'b1;
        // RULE21 pop return address
        if (isRet || isReti) begin
          pc <= retAddr;
          sp <= sp - 1'b1;
        end
      end
    end
  end

  // stack storage needs no reset, only the pointer does
  always_ff @(posedge clk) begin
    if (exec && (cls == CLS_CALL)) stack[sp] <= pc + 16'h0001;
  end

  // accumulator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc <= BYTE_RST;
    end else if (movcPend) begin
      acc <= romData[7:0];
    end else if (exec) begin
      if (isMul) acc <= prod[7:0];
      else if (wrA) acc <= aluBus.res;
    end
  end

  // core-held system registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rHold <= BYTE_RST;
      ptrY <= BYTE_RST;
      ptrZ <= BYTE_RST;
      rbank <= '0;
    end else begin
      if (doWr && (bank == '0)) begin
        case (addr)
          SYS_R: rHold <= wrData;
          SYS_Y: ptrY <= wrData;
          SYS_Z: ptrZ <= wrData;
          SYS_RBANK: rbank <= wrData[BANK_W-1:0];
          default: ;
        endcase
      end
      // RULE4 second cycle fetch
      if (movcPend) rHold <= romData[15:8];
      // RULE10 high byte to R
      else if (exec && isMul) rHold <= prod[15:8];
    end
  end

  // flags; an instruction's own flag result overrides a store to the flag register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      carryFlag <= 1'b0;
      halfCarryFlag <= 1'b0;
      zeroResultFlag <= 1'b0;
    end else if (exec) begin
      if (doWr && (bank == '0) && (addr == SYS_PFLAG)) begin
        {carryFlag, halfCarryFlag, zeroResultFlag} <= wrData[2:0];
      end
      if (updC) carryFlag <= aluBus.cout;
      if (updDC) halfCarryFlag <= aluBus.hcOut;
      if (updZ) zeroResultFlag <= isMul ? (prod[7:0] == 8'h00) : (aluBus.res == 8'h00);
    end
  end

  // external write issued one cycle after execute; the wait state hides it when N is 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramWe <= 1'b0;
      ramWrAddr <= '0;
      ramWrData <= BYTE_RST;
    end else begin
      ramWe <= doWr && !intHit;
      if (doWr) begin
        ramWrAddr <= {bank, addr};
        ramWrData <= wrData;
      end
    end
  end

  // global enable: the return sets it, and wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) gie <= 1'b0;
    else if (exec && isReti) gie <= 1'b1;
    else if (gieClear) gie <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_load_flags: assert property (  // RULE1
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_MOV_AM) |=> state == ST_RUN &&
      $stable(carryFlag) && $stable(halfCarryFlag) && (zeroResultFlag == (acc == 8'h00)))
    else $error("load took extra cycle or touched carry flags");
  a_store_quiet: assert property (  // RULE1
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_MOV_MA) |=> state == ST_RUN &&
      $stable({carryFlag, halfCarryFlag, zeroResultFlag}))
    else $error("store stalled or changed flags");
  a_imm_window: assert property (  // RULE2
    @(posedge clk) disable iff (sys_rst) exec && isB0Imm |-> addr[7:3] == 5'h10 && bank == '0 ##1 state == ST_RUN)
    else $error("bank-0 immediate store outside window or stalled");
  a_xch_swap: assert property (  // RULE3
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_XCH) && !intHit |=>
      acc == $past(memVal) && ramWe && ramWrData == $past(acc))
    else $error("exchange did not swap");
  a_penalty_wait: assert property (  // RULE23
    @(posedge clk) disable iff (sys_rst) exec && memDest && penalty |=> (state == ST_WAIT) == $past(!inBank0Sys))
    else $error("write penalty wrong for destination");
  a_rom_table_read_fetch: assert property (  // RULE4
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_ROM_TABLE_READ) |=> state == ST_WAIT &&
      romAddr == {ptrY, ptrZ} ##1 state == ST_RUN && acc == $past(romData[7:0]) && rHold == $past(romData[15:8]))
    else $error("table read wrong");
  a_mul_bytes: assert property (  // RULE10
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_MUL) |=> {rHold, acc} == $past(prod) &&
      state == ST_WAIT ##1 state == ST_RUN)
    else $error("product bytes or timing wrong");
  a_jump_target: assert property (  // RULE19
    @(posedge clk) disable iff (sys_rst) exec && (cls == CLS_JMP) |=> pc == $past(jumpTarget) && state == ST_WAIT)
    else $error("jump target or timing wrong");
  a_call_push: assert property (  // RULE20
    @(posedge clk) disable iff (sys_rst) exec && (cls == CLS_CALL) |=> sp == SP_W'($past(sp) + 1'b1) &&
      stack[$past(sp)] == PC_W'($past(pc) + 16'h0001))
    else $error("call did not push return address");
  a_interrupt_return_gie: assert property (  // RULE21
    @(posedge clk) disable iff (sys_rst) exec && isReti |=> gie && pc == $past(retAddr) && state == ST_WAIT)
    else $error("interrupt return wrong");
  a_skip_slot: assert property (  // RULE22
    @(posedge clk) disable iff (sys_rst) exec && skipTake && !stall |=> skipNext && !exec ##1 !skipNext)
    else $error("taken skip did not cost exactly one slot");
  a_sub_carry: assert property (  // RULE8
    @(posedge clk) disable iff (sys_rst) exec && isMisc && (op == OP_SUB_AI) |=>
      carryFlag == ($past(acc) >= $past(opnd)) && acc == 8'($past(acc) - $past(opnd)))
    else $error("difference result or carry wrong");
endmodule : mcuie_core
`default_nettype wire

/* pkg/mcuie_pkg.sv */
`default_nettype none
package mcuie_pkg;
  localparam int PC_W = 16;
  localparam int BANK_W_DEF = 4;
  localparam int STACK_DEPTH_DEF = 8;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // instruction class in word bits 15:14
  localparam logic [1:0] CLS_MISC = 2'h0, CLS_CALL = 2'h1, CLS_JMP = 2'h2, CLS_BIT = 2'h3;
  // misc opcodes in word bits 13:8, operand in bits 7:0
  localparam logic [5:0] OP_NOP = 6'h00, OP_MOV_AM = 6'h01, OP_MOV_MA = 6'h02, OP_BANK0_TRANSFER_AM = 6'h03,
    OP_BANK0_TRANSFER_MA = 6'h04, OP_MOV_AI = 6'h05, OP_XCH = 6'h06, OP_BANK0_EXCHANGE = 6'h07, OP_ROM_TABLE_READ = 6'h08,
    OP_ADC_AM = 6'h09, OP_ADC_MA = 6'h0A, OP_ADD_AM = 6'h0B, OP_ADD_MA = 6'h0C, OP_BANK0_SUM_MA = 6'h0D,
    OP_ADD_AI = 6'h0E, OP_SBC_AM = 6'h0F, OP_SBC_MA = 6'h10, OP_SUB_AM = 6'h11, OP_SUB_MA = 6'h12,
    OP_SUB_AI = 6'h13, OP_DAA = 6'h14, OP_MUL = 6'h15, OP_AND_AM = 6'h16, OP_AND_MA = 6'h17,
    OP_AND_AI = 6'h18, OP_OR_AM = 6'h19, OP_OR_MA = 6'h1A, OP_OR_AI = 6'h1B, OP_XOR_AM = 6'h1C,
    OP_XOR_MA = 6'h1D, OP_XOR_AI = 6'h1E, OP_SWAP = 6'h1F, OP_NIBBLE_EXCHANGE_MEM = 6'h20, OP_RRC = 6'h21,
    OP_ROTATE_RIGHT_CARRY_MEM = 6'h22, OP_RLC = 6'h23, OP_ROTATE_LEFT_CARRY_MEM = 6'h24, OP_CLR = 6'h25, OP_COMPARE_SKIP_AI = 6'h26,
    OP_COMPARE_SKIP_AM = 6'h27, OP_INCREMENT_SKIP_ACC = 6'h28, OP_INCREMENT_MEM_SKIP = 6'h29, OP_DECREMENT_SKIP_ACC = 6'h2A, OP_DECREMENT_MEM_SKIP = 6'h2B,
    OP_RET = 6'h2C, OP_INTERRUPT_RETURN = 6'h2D;
  // opcodes 38..3F: bank-0 immediate store, low three bits pick the address
  localparam logic [2:0] B0IMM_GRP = 3'h7;
  localparam logic [7:0] B0IMM_BASE = 8'h80;
  // system registers held inside the core, bank 0
  localparam logic [7:0] SYS_R = 8'h82, SYS_Z = 8'h83, SYS_Y = 8'h84, SYS_PFLAG = 8'h86, SYS_RBANK = 8'h87;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_SWAP, ALU_RRC, ALU_RLC, ALU_INC, ALU_DEC, ALU_DAA
  } mcuie_alu_e;
  typedef enum logic {ST_RUN, ST_WAIT} mcuie_state_e;
endpackage : mcuie_pkg
`default_nettype wire

/* pkg/mcuie_alu_if.sv */
`default_nettype none
interface mcuie_alu_if;
  import mcuie_pkg::*;
  mcuie_alu_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic hcIn;
  logic [7:0] res;
  logic cout;
  logic hcOut;
  modport core (output op, a, b, cin, hcIn, input res, cout, hcOut);
  modport alu (input op, a, b, cin, hcIn, output res, cout, hcOut);
endinterface : mcuie_alu_if
`default_nettype wire

/* rtl/mcuie_alu.sv */
`default_nettype none
module mcuie_alu
  import mcuie_pkg::*;
(
  mcuie_alu_if.alu bus
);
  logic [7:0] bx;
  logic [8:0] sum;
  logic [4:0] low;
  logic [8:0] adj;

  // subtract is a plus inverted b, so carry out reads as "no borrow"
  assign bx = (bus.op == ALU_SUB) ? ~bus.b : bus.b;
  assign sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, bus.cin};
  // RULE24 nibble carry out
  assign low = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, bus.cin};

  ////////////////////////////////////////////////////////////////////////////
  // result select; flags the core does not update are don't-care here
  always_comb begin
    adj = {1'b0, bus.a};
    bus.res = bus.b;
    bus.cout = bus.cin;
    bus.hcOut = bus.hcIn;
    unique case (bus.op)
      ALU_ADD, ALU_SUB: begin
        bus.res = sum[7:0];
        bus.cout = sum[8];
        bus.hcOut = low[4];
      end
      ALU_AND: bus.res = bus.a & bus.b;
      ALU_OR: bus.res = bus.a | bus.b;
      ALU_XOR: bus.res = bus.a ^ bus.b;
      ALU_PASS: bus.res = bus.b;
      ALU_SWAP: bus.res = {bus.a[3:0], bus.a[7:4]};
      ALU_RRC: begin
        bus.res = {bus.cin, bus.a[7:1]};
        bus.cout = bus.a[0];
      end
      ALU_RLC: begin
        bus.res = {bus.a[6:0], bus.cin};
        bus.cout = bus.a[7];
      end
      ALU_INC: bus.res = bus.a + 8'h01;
      ALU_DEC: bus.res = bus.a - 8'h01;
      ALU_DAA: begin
        // both tests use the unadjusted value, as a decimal adjust must
        if (bus.hcIn || (bus.a[3:0] > 4'h9)) adj = adj + 9'h006;
        if (bus.cin || (bus.a > 8'h99)) adj = adj + 9'h060;
        bus.res = adj[7:0];
        bus.cout = bus.cin || (bus.a > 8'h99);
      end
      // four codes of the 4-bit op are unused
      default: ;
    endcase
  end
endmodule : mcuie_alu
`default_nettype wire

/* verif/mcuie_mem_model.sv */
`default_nettype none
module mcuie_mem_model
  import mcuie_pkg::*;
#(
  parameter int BANK_W = BANK_W_DEF
) (
  input wire logic clk,
  input wire logic [PC_W-1:0] romAddr,
  output logic [15:0] romData,
  input wire logic [BANK_W+7:0] ramRdAddr,
  output logic [7:0] ramRdData,
  input wire logic ramWe,
  input wire logic [BANK_W+7:0] ramWrAddr,
  input wire logic [7:0] ramWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [0:255];
  logic [7:0] ram [0:(1<<(BANK_W+8))-1];
  // async rom: only 256 words, upper address bits alias
  assign romData = rom[romAddr[7:0]];
  // async read; the core forwards its own pending write
  assign ramRdData = ram[ramRdAddr];
  // write lands on the edge that ends the strobe cycle
  always @(posedge clk) begin
    if (ramWe) begin
      ram[ramWrAddr] <= ramWrData;
    end
  end
endmodule : mcuie_mem_model
`default_nettype wire

/* verif/mcu_instruction_execute_tb.sv */
`default_nettype none
module mcu_instruction_execute_tb import mcuie_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [15:0] romAddr, romData;
  logic [11:0] ramRdAddr, ramWrAddr;
  logic [7:0] ramRdData, ramWrData, acc;
  logic ramWe, gie, carryFlag, halfCarryFlag, zeroResultFlag;
  logic [1:0] pageBits = 2'b00;
  logic gieClr = 1'b0;
  int errorCnt = 0;
  int numChecks = 0;
  integer seed = 32'h090E;
  logic [5:0] ops [0:16] = '{OP_ADD_AI, OP_SUB_AI, OP_AND_AI, OP_OR_AI, OP_XOR_AI, OP_COMPARE_SKIP_AI, OP_ADC_AM,
    OP_SBC_AM, OP_ADD_AM, OP_SUB_AM, OP_COMPARE_SKIP_AM, OP_MOV_AM, OP_INCREMENT_SKIP_ACC, OP_DECREMENT_SKIP_ACC, OP_SWAP, OP_RRC, OP_RLC};
  logic [5:0] op;
  logic [7:0] a, b;
  logic [11:0] e;
  int n;
  initial begin
    forever #12.5 clk = ~clk;
  end
  mcuie_core u_dut (.clk(clk), .sys_rst(sysRst), .romAddr(romAddr), .romData(romData), .ramRdAddr(ramRdAddr),
    .ramRdData(ramRdData), .ramWe(ramWe), .ramWrAddr(ramWrAddr), .ramWrData(ramWrData), .romPageBits(pageBits),
    .gieClear(gieClr), .gie(gie), .acc(acc), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
    .zeroResultFlag(zeroResultFlag));
  mcuie_mem_model u_mem (.clk(clk), .romAddr(romAddr), .romData(romData), .ramRdAddr(ramRdAddr),
    .ramRdData(ramRdData), .ramWe(ramWe), .ramWrAddr(ramWrAddr), .ramWrData(ramWrData));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic endSim();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : endSim
  // every program ends in a jump loop, so no write is in flight when memories are wiped
  task automatic clearAll();
    @(posedge clk);
    sysRst <= 1'b1;
    for (int i = 0; i < 4096; i++) u_mem.ram[i] = 8'h00;
    for (int i = 0; i < 256; i++) u_mem.rom[i] = 16'h0000;
  endtask : clearAll
  task automatic run();
    repeat (10) @(posedge clk);
    sysRst <= 1'b0;
  endtask : run
  // expected {skip, C, DC, Z, acc}; flags start at zero after reset
  function automatic logic [11:0] expect_op(input logic [5:0] o, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic c, d, z, k, bor;
    c = 1'b0; d = 1'b0; k = 1'b0; z = 1'b0;
    bor = (o == OP_SBC_AM);
    s = {1'b0, x} + y;
    h = x[3:0] + y[3:0];
    r = s[7:0];
    case (o)
      OP_ADD_AI, OP_ADD_AM, OP_ADC_AM: begin c = s[8]; d = h[4]; z = (r == 8'h00); end
      OP_SUB_AI, OP_SUB_AM, OP_SBC_AM, OP_COMPARE_SKIP_AI, OP_COMPARE_SKIP_AM: begin
        s = {1'b0, x} - y - bor;
        h = x[3:0] - y[3:0] - bor;
        r = s[7:0];
        c = ~s[8];
        d = ~h[4];
        z = (r == 8'h00);
        if (o == OP_COMPARE_SKIP_AI || o == OP_COMPARE_SKIP_AM) begin
          d = 1'b0; k = z; r = x;
        end
      end
      OP_AND_AI: begin r = x & y; z = (r == 8'h00); end
      OP_OR_AI: begin r = x | y; z = (r == 8'h00); end
      OP_XOR_AI: begin r = x ^ y; z = (r == 8'h00); end
      OP_MOV_AM: begin r = y; z = (r == 8'h00); end
      OP_INCREMENT_SKIP_ACC: begin r = y + 8'h01; k = (r == 8'h00); end
      OP_DECREMENT_SKIP_ACC: begin r = y - 8'h01; k = (r == 8'h00); end
      OP_SWAP: r = {y[3:0], y[7:4]};
      OP_RRC: begin r = {1'b0, y[7:1]}; c = y[0]; end
      default: begin r = {y[6:0], 1'b0}; c = y[7]; end
    endcase
    return {k, c, d, z, r};
  endfunction : expect_op
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    errorCnt++;
    endSim();
  end
  initial begin
    // random operands, every op in turn; a stored copy shows whether a skip happened
    for (int t = 0; t < 119; t++) begin
      op = ops[t % 17];
      a = $random(seed);
      b = $random(seed);
      if (t % 4 == 1) b = a;
      if (t % 4 == 2) b = (t % 8 == 2) ? 8'hFF : 8'h01;
      clearAll();
      u_mem.rom[0] = {2'b00, OP_MOV_AI, a};
      u_mem.rom[1] = {2'b00, op, (t % 17 < 6) ? b : 8'h20};
      u_mem.rom[2] = {2'b00, OP_MOV_MA, 8'h10};
      u_mem.rom[3] = {2'b10, 14'd3};
      u_mem.ram[8'h20] = b;
      u_mem.ram[8'h10] = 8'h5A;
      e = expect_op(op, a, b);
      run();
      repeat (8) @(posedge clk);
      #1;
      check("acc", acc, e[7:0]);
      check("carry", carryFlag, e[10]);
      check("half", halfCarryFlag, e[9]);
      check("zero", zeroResultFlag, e[8]);
      check("stored", u_mem.ram[8'h10], e[11] ? 8'h5A : e[7:0]);
    end
    // directed walk: exchange, table read, product, memory increment with skip, call, interrupt return
    clearAll();
    pageBits <= 2'b10;
    u_mem.rom[0] = {2'b00, OP_MOV_AI, 8'h12};
    u_mem.rom[1] = {2'b00, OP_XCH, 8'h20};
    u_mem.rom[2] = {2'b00, 3'b111, 3'h3, 8'h40};
    u_mem.rom[3] = {2'b00, OP_ROM_TABLE_READ, 8'h00};
    u_mem.rom[4] = {2'b00, OP_MUL, 8'h21};
    u_mem.rom[5] = {2'b00, OP_MOV_MA, 8'h30};
    u_mem.rom[6] = {2'b00, OP_MOV_AM, SYS_R};
    u_mem.rom[7] = {2'b00, OP_MOV_MA, 8'h31};
    u_mem.rom[8] = {2'b00, OP_INCREMENT_MEM_SKIP, 8'h22};
    u_mem.rom[9] = {2'b00, OP_MOV_AI, 8'h77};
    u_mem.rom[10] = {2'b01, 14'h0020};
    u_mem.rom[11] = {2'b10, 14'd11};
    u_mem.rom[8'h20] = {2'b00, OP_INTERRUPT_RETURN, 8'h00};
    u_mem.rom[8'h40] = 16'hBEEF;
    u_mem.ram[8'h20] = 8'h34;
    u_mem.ram[8'h21] = 8'h02;
    u_mem.ram[8'h22] = 8'hFF;
    run();
    for (n = 1; n <= 40; n++) begin
      @(posedge clk);
      #1;
      if (romAddr === 16'd10) break;
    end
    // a timed-out walk counts here and again in the cycle check, then falls through to the report
    if (n > 40) errorCnt++;
    check("cycles", n, 16'd14);
    check("xchg", u_mem.ram[8'h20], 8'h12);
    check("prodlo", u_mem.ram[8'h30], 8'hDE);
    check("prodhi", u_mem.ram[8'h31], 8'h01);
    check("incm", u_mem.ram[8'h22], 8'h00);
    check("accfin", acc, 8'h01);
    // call to a paged target, interrupt return to 11, then a paged jump loop
    repeat (6) @(posedge clk);
    #1;
    check("jmppage", romAddr, 16'h800B);
    check("gieset", gie, 1'b1);
    @(posedge clk);
    gieClr <= 1'b1;
    @(posedge clk);
    gieClr <= 1'b0;
    #1;
    check("gieclr", gie, 1'b0);
    endSim();
  end
endmodule : mcu_instruction_execute_tb
`default_nettype wire
